// ---- shared/adc_cfg_params.svh ----
// offsets, field positions, reset values and timing counts of the config bank
`ifndef ADC_CFG_PARAMS_SVH
`define ADC_CFG_PARAMS_SVH

`define OFS_POWER_MODE     8'h08
`define OFS_GLOBAL_CLOCK   8'h09
`define OFS_CLOCK_DIVIDER  8'h0B
`define OFS_TEST_PATTERN   8'h0D
`define OFS_OFFSET_TRIM    8'h10
`define OFS_USER1_LO       8'h19
`define OFS_USER1_HI       8'h1A
`define OFS_USER2_LO       8'h1B
`define OFS_USER2_HI       8'h1C
`define OFS_TRANSFER       8'hFF

`define RST_POWER_MODE     8'h00
`define RST_GLOBAL_CLOCK   8'h01
`define RST_CLOCK_DIVIDER  8'h00
`define RST_TEST_PATTERN   8'h00
`define RST_OFFSET_TRIM    8'h00
`define RST_USER_BYTE      8'h00

`define TRANSFER_CMD       8'h01
`define POS_DCS            0
`define POS_DIV_RATIO      0
`define POS_DIV_PHASE      3
`define POS_TEST_MODE      0
`define POS_PN_SHORT_RST   4
`define POS_PN_LONG_RST    5
`define POS_USER_SINGLE    7
`define POS_OFFSET         0

`define PN_LONG_SEED       23'h7FFFFF
`define PN_SHORT_SEED      9'h1FF
`define DIV_PHASE_DEPTH    8

`endif

// ---- shared/adc_cfg_pkg.sv ----
// types shared by the configuration bank and its datapath
package adc_cfg_pkg;

    typedef enum logic [1:0] {
        PWR_NORMAL    = 2'b00,
        PWR_FULL_DOWN = 2'b01,
        PWR_STANDBY   = 2'b10,
        PWR_RESERVED  = 2'b11
    } power_mode_t;

    typedef enum logic [3:0] {
        TM_OFF        = 4'b0000,
        TM_MIDSCALE   = 4'b0001,
        TM_POS_FS     = 4'b0010,
        TM_NEG_FS     = 4'b0011,
        TM_CHECKER    = 4'b0100,
        TM_PN_LONG    = 4'b0101,
        TM_PN_SHORT   = 4'b0110,
        TM_WORD_TOG   = 4'b0111,
        TM_USER       = 4'b1000,
        TM_RAMP       = 4'b1111
    } test_mode_t;

    typedef enum logic [1:0] {
        USR_FIRST  = 2'b00,
        USR_SECOND = 2'b01,
        USR_DONE   = 2'b10
    } user_seq_t;

    typedef struct packed {
        logic       wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        power_mode_t power_mode;
        logic        dcs_en;
        logic [2:0]  div_phase;
        logic [2:0]  div_ratio;
        logic        user_single;
        logic        pn_long_rst;
        logic        pn_short_rst;
        test_mode_t  test_mode;
        logic [5:0]  offset;
        logic [15:0] user1;
        logic [15:0] user2;
    } active_cfg_t;

endpackage : adc_cfg_pkg

// ---- core/clock_divider.sv ----
// input clock divider with programmable phase delay
`timescale 1ns/1ns
`include "adc_cfg_params.svh"
module clock_divider (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // settings
    input  wire logic [2:0] ratio,
    input  wire logic [2:0] phase,
    // divided strobe
    output logic            tick
);
    logic [2:0]                    count;
    logic                          raw_tick;
    logic [`DIV_PHASE_DEPTH-1:0]   delay_line;

    assign raw_tick = (count == 3'h0);

    // count wraps after ratio+1 input cycles
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            count <= 3'h0;
        end else if (count >= ratio) begin
            count <= 3'h0; // [RULE_03]
        end else begin
            count <= count + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            delay_line <= '0;
        end else begin
            delay_line <= {delay_line[`DIV_PHASE_DEPTH-2:0], raw_tick};
        end
    end

    // phase picks 0..7 cycles of delay
    always_comb begin
        if (phase == 3'h0) begin
            tick = raw_tick;
        end else begin
            tick = delay_line[phase - 3'h1]; // [RULE_12]
        end
    end
endmodule : clock_divider

// ---- core/test_pattern_gen.sv ----
// output test pattern generator
`timescale 1ns/1ns
`include "adc_cfg_params.svh"
module test_pattern_gen #(
    parameter int W = 11
) (
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    // control
    input  wire adc_cfg_pkg::active_cfg_t cfg,
    input  wire logic                     advance,
    // pattern word
    output logic [W-1:0]                  pattern
);
    logic [22:0]             pn_long;
    logic [8:0]              pn_short;
    logic [W-1:0]            ramp;
    logic                    phase_flip;
    adc_cfg_pkg::user_seq_t  user_state;
    logic [W-1:0]            checker_a;
    logic [2*((W+1)/2)-1:0]  checker_wide;
    logic [17:0]             pn_short_pair;

    assign checker_wide  = {((W+1)/2){2'b10}};
    assign checker_a     = checker_wide[W-1:0];
    assign pn_short_pair = {pn_short, pn_short};

    always_ff @(posedge clk_sys) begin
        if (!rst_n || cfg.pn_long_rst) begin
            pn_long <= `PN_LONG_SEED;
        end else if (advance) begin
            pn_long <= {pn_long[21:0], pn_long[22] ^ pn_long[17]}; // [RULE_06]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n || cfg.pn_short_rst) begin
            pn_short <= `PN_SHORT_SEED;
        end else if (advance) begin
            pn_short <= {pn_short[7:0], pn_short[8] ^ pn_short[4]}; // [RULE_06]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ramp       <= '0;
            phase_flip <= 1'b0;
        end else if (advance) begin
            ramp       <= ramp + 1'b1;
            phase_flip <= ~phase_flip;
        end
    end

    // user words: first, second, then repeat or stop
    always_ff @(posedge clk_sys) begin
        if (!rst_n || cfg.test_mode != adc_cfg_pkg::TM_USER) begin
            user_state <= adc_cfg_pkg::USR_FIRST;
        end else if (advance) begin
            case (user_state)
                adc_cfg_pkg::USR_FIRST: begin
                    user_state <= adc_cfg_pkg::USR_SECOND;
                end
                adc_cfg_pkg::USR_SECOND: begin
                    user_state <= cfg.user_single ? adc_cfg_pkg::USR_DONE
                                                  : adc_cfg_pkg::USR_FIRST; // [RULE_09]
                end
                default: begin
                    user_state <= cfg.user_single ? adc_cfg_pkg::USR_DONE
                                                  : adc_cfg_pkg::USR_FIRST; // [RULE_09]
                end
            endcase
        end
    end

    always_comb begin
        case (cfg.test_mode) // [RULE_05]
            adc_cfg_pkg::TM_MIDSCALE: pattern = '0;
            adc_cfg_pkg::TM_POS_FS:   pattern = {1'b0, {(W-1){1'b1}}};
            adc_cfg_pkg::TM_NEG_FS:   pattern = {1'b1, {(W-1){1'b0}}};
            adc_cfg_pkg::TM_CHECKER:  pattern = phase_flip ? ~checker_a : checker_a;
            adc_cfg_pkg::TM_PN_LONG:  pattern = pn_long[22 -: W]; // [RULE_06]
            adc_cfg_pkg::TM_PN_SHORT: pattern = pn_short_pair[17 -: W]; // [RULE_06]
            adc_cfg_pkg::TM_WORD_TOG: pattern = {W{phase_flip}};
            adc_cfg_pkg::TM_RAMP:     pattern = ramp;
            adc_cfg_pkg::TM_USER: begin
                case (user_state) // [RULE_07]
                    adc_cfg_pkg::USR_FIRST:  pattern = cfg.user1[15 -: W];
                    adc_cfg_pkg::USR_SECOND: pattern = cfg.user2[15 -: W];
                    default:                 pattern = '0; // [RULE_09]
                endcase
            end
            default: pattern = '0;
        endcase
    end
endmodule : test_pattern_gen

// ---- core/adc_config_register_bank.sv ----
// shadowed configuration registers and the datapath they steer
//
// Operation
// RULE_01: power-down code 00 is normal operation, 01 is full power-down.
// RULE_02: code 10 puts the device in standby; code 11 is reserved.
// RULE_03: clock divide field divides input clock by field value plus one.
// RULE_04: any selected test mode replaces converted samples on the outputs.
// RULE_05: codes 0001-0100, 0111, 1111 give midscale, fs, checker, toggle, ramp.
// RULE_06: code 0101 gives long pseudorandom sequence, 0110 the short one.
// RULE_07: code 1000 outputs the user-programmed pattern words.
// RULE_08: host never selects unused test codes 1001 through 1110.
// RULE_09: user control 0 repeats patterns; 1 sends once then zeros.
// RULE_10: shadowed registers apply together on transfer write; transfer bit self-clears.
// RULE_11: divide ratio other than 000 forces stabilizer on; enable resets to 1.
// RULE_12: divider phase field delays divider output by 0 to 7 cycles.
`timescale 1ns/1ns
`include "adc_cfg_params.svh"
module adc_config_register_bank #(
    parameter int W = 11
) (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // control port, after deframing
    input  wire adc_cfg_pkg::reg_req_t  req,
    output logic [7:0]                  rd_data,
    // converter samples
    input  wire logic [W-1:0]           adc_sample,
    // output data
    output logic [W-1:0]                data_out,
    output logic                        data_valid,
    // analog controls
    output logic                        sample_tick,
    output logic                        dcs_active,
    output logic                        power_down,
    output logic                        standby
);
    logic [7:0]                m_power;
    logic [7:0]                m_clock;
    logic [7:0]                m_divider;
    logic [7:0]                m_test;
    logic [7:0]                m_offset;
    logic [7:0]                m_user1_lo;
    logic [7:0]                m_user1_hi;
    logic [7:0]                m_user2_lo;
    logic [7:0]                m_user2_hi;
    logic                      transfer;
    adc_cfg_pkg::active_cfg_t  act;
    adc_cfg_pkg::active_cfg_t  next_act;
    logic [7:0]                next_rd_data;
    logic [W-1:0]              pattern;
    logic                      test_active;
    logic                      run;
    logic signed [W:0]         trimmed;
    logic [W-1:0]              next_data;

    // master copies, written by the host
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            m_power   <= `RST_POWER_MODE;
            m_clock   <= `RST_GLOBAL_CLOCK;
            m_divider <= `RST_CLOCK_DIVIDER;
            m_test    <= `RST_TEST_PATTERN;
            m_offset  <= `RST_OFFSET_TRIM;
        end else if (req.wr_en) begin
            case (req.addr)
                `OFS_POWER_MODE:    m_power   <= req.wdata & 8'h03;
                `OFS_GLOBAL_CLOCK:  m_clock   <= req.wdata & 8'h01;
                `OFS_CLOCK_DIVIDER: m_divider <= req.wdata & 8'h3F;
                `OFS_TEST_PATTERN:  m_test    <= req.wdata & 8'hBF;
                `OFS_OFFSET_TRIM:   m_offset  <= req.wdata & 8'h3F;
                default: begin
                end
            endcase
        end
    end

    // user pattern bytes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            m_user1_lo <= `RST_USER_BYTE;
            m_user1_hi <= `RST_USER_BYTE;
            m_user2_lo <= `RST_USER_BYTE;
            m_user2_hi <= `RST_USER_BYTE;
        end else if (req.wr_en) begin
            case (req.addr)
                `OFS_USER1_LO: m_user1_lo <= req.wdata;
                `OFS_USER1_HI: m_user1_hi <= req.wdata;
                `OFS_USER2_LO: m_user2_lo <= req.wdata;
                `OFS_USER2_HI: m_user2_hi <= req.wdata;
                default: begin
                end
            endcase
        end
    end

    // transfer command decode
    assign transfer = req.wr_en && (req.addr == `OFS_TRANSFER)
                      && (req.wdata == `TRANSFER_CMD); // [RULE_10]

    // active set built from the master copies
    always_comb begin
        next_act              = act;
        next_act.power_mode   = adc_cfg_pkg::power_mode_t'(m_power[1:0]);
        next_act.dcs_en       = m_clock[`POS_DCS];
        next_act.div_ratio    = m_divider[`POS_DIV_RATIO +: 3];
        next_act.div_phase    = m_divider[`POS_DIV_PHASE +: 3];
        next_act.test_mode    = adc_cfg_pkg::test_mode_t'(m_test[`POS_TEST_MODE +: 4]);
        next_act.pn_short_rst = m_test[`POS_PN_SHORT_RST];
        next_act.pn_long_rst  = m_test[`POS_PN_LONG_RST];
        next_act.user_single  = m_test[`POS_USER_SINGLE];
        next_act.offset       = m_offset[`POS_OFFSET +: 6];
        next_act.user1        = {m_user1_hi, m_user1_lo};
        next_act.user2        = {m_user2_hi, m_user2_lo};
    end

    // shadow registers load together on transfer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            act              <= '0;
            act.power_mode   <= adc_cfg_pkg::power_mode_t'(2'(`RST_POWER_MODE));
            act.dcs_en       <= 1'(`RST_GLOBAL_CLOCK);  // [RULE_11]
            act.test_mode    <= adc_cfg_pkg::TM_OFF;
        end else if (transfer) begin
            act <= next_act; // [RULE_10]
        end
    end

    // readback of the master copies; transfer reads as cleared
    always_comb begin
        case (req.addr)
            `OFS_POWER_MODE:    next_rd_data = m_power;
            `OFS_GLOBAL_CLOCK:  next_rd_data = m_clock;
            `OFS_CLOCK_DIVIDER: next_rd_data = m_divider;
            `OFS_TEST_PATTERN:  next_rd_data = m_test;
            `OFS_OFFSET_TRIM:   next_rd_data = m_offset;
            `OFS_USER1_LO:      next_rd_data = m_user1_lo;
            `OFS_USER1_HI:      next_rd_data = m_user1_hi;
            `OFS_USER2_LO:      next_rd_data = m_user2_lo;
            `OFS_USER2_HI:      next_rd_data = m_user2_hi;
            `OFS_TRANSFER:      next_rd_data = 8'h00; // [RULE_10]
            default:            next_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    // power state decode
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            power_down <= 1'b0;
            standby    <= 1'b0;
        end else begin
            case (act.power_mode)
                adc_cfg_pkg::PWR_FULL_DOWN: begin
                    power_down <= 1'b1; // [RULE_01]
                    standby    <= 1'b0;
                end
                adc_cfg_pkg::PWR_STANDBY: begin
                    power_down <= 1'b0;
                    standby    <= 1'b1; // [RULE_02]
                end
                default: begin
                    power_down <= 1'b0; // [RULE_01]
                    standby    <= 1'b0;
                end
            endcase
        end
    end

    assign run = (act.power_mode == adc_cfg_pkg::PWR_NORMAL)
                 || (act.power_mode == adc_cfg_pkg::PWR_RESERVED);

    // stabilizer forced on by any nonzero divide ratio
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dcs_active <= 1'b1;
        end else begin
            dcs_active <= act.dcs_en || (act.div_ratio != 3'h0); // [RULE_11]
        end
    end

    clock_divider u_divider (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ratio   (act.div_ratio),
        .phase   (act.div_phase),
        .tick    (sample_tick)
    ); // [RULE_03] [RULE_12]

    test_pattern_gen #(
        .W (W)
    ) u_patterns (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .cfg     (act),
        .advance (sample_tick && run),
        .pattern (pattern)
    );

    // unused codes fall back to converted data
    always_comb begin
        case (act.test_mode)
            adc_cfg_pkg::TM_MIDSCALE,
            adc_cfg_pkg::TM_POS_FS,
            adc_cfg_pkg::TM_NEG_FS,
            adc_cfg_pkg::TM_CHECKER,
            adc_cfg_pkg::TM_PN_LONG,
            adc_cfg_pkg::TM_PN_SHORT,
            adc_cfg_pkg::TM_WORD_TOG,
            adc_cfg_pkg::TM_USER,
            adc_cfg_pkg::TM_RAMP: test_active = 1'b1; // [RULE_08]
            default:              test_active = 1'b0;
        endcase
    end

    // offset trim with saturation
    assign trimmed = $signed({adc_sample[W-1], adc_sample})
                     + $signed({{(W-5){act.offset[5]}}, act.offset});

    always_comb begin
        if (trimmed > $signed({2'b00, {(W-1){1'b1}}})) begin
            next_data = {1'b0, {(W-1){1'b1}}};
        end else if (trimmed < $signed({2'b11, {(W-1){1'b0}}})) begin
            next_data = {1'b1, {(W-1){1'b0}}};
        end else begin
            next_data = trimmed[W-1:0];
        end
    end

    // output word, updated on each sample tick
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            data_out   <= '0;
            data_valid <= 1'b0;
        end else if (!run) begin
            data_out   <= '0; // [RULE_01] [RULE_02]
            data_valid <= 1'b0;
        end else if (sample_tick) begin
            data_out   <= test_active ? pattern : next_data; // [RULE_04]
            data_valid <= 1'b1;
        end else begin
            data_valid <= 1'b0;
        end
    end
endmodule : adc_config_register_bank

// ---- testbench/adc_cfg_checker.sv ----
// port assertions for the config register bank
`timescale 1ns/1ns
`include "adc_cfg_params.svh"
module adc_cfg_checker #(
    parameter int W = 11
) (
    // clock and reset
    input wire logic                  clk_sys,
    input wire logic                  rst_n,
    // register port
    input wire adc_cfg_pkg::reg_req_t req,
    input wire logic [7:0]            rd_data,
    // data path
    input wire logic [W-1:0]          adc_sample,
    input wire logic [W-1:0]          data_out,
    input wire logic                  data_valid,
    // analog controls
    input wire logic                  sample_tick,
    input wire logic                  dcs_active,
    input wire logic                  power_down,
    input wire logic                  standby
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_valid_tick; data_valid |-> $past(sample_tick); endproperty
    a_valid_tick: assert property (p_valid_tick) else $error("valid without tick");
    property p_down_quiet; power_down [*3] |-> !data_valid && data_out == '0; endproperty
    a_down_quiet: assert property (p_down_quiet) else $error("data in power-down");
    property p_stby_quiet; standby [*3] |-> !data_valid && data_out == '0; endproperty
    a_stby_quiet: assert property (p_stby_quiet) else $error("data in standby");
    property p_one_mode; !(power_down && standby); endproperty
    a_one_mode: assert property (p_one_mode) else $error("two power modes");
    property p_xfer_rd; $past(req.addr) == `OFS_TRANSFER |-> rd_data == 8'h00; endproperty
    a_xfer_rd: assert property (p_xfer_rd) else $error("transfer bit stuck");
    property p_tm_mask; $past(req.addr) == `OFS_TEST_PATTERN |-> !rd_data[6]; endproperty
    a_tm_mask: assert property (p_tm_mask) else $error("open bit set");
    property p_dcs_rst; $rose(rst_n) |-> dcs_active; endproperty
    a_dcs_rst: assert property (p_dcs_rst) else $error("stabilizer off at reset");
    property p_gap_dcs; !sample_tick [*3] |-> dcs_active; endproperty
    a_gap_dcs: assert property (p_gap_dcs) else $error("divider without stabilizer");
    property p_hold;
        !$past(sample_tick || power_down || standby) && !(power_down || standby)
            |-> $stable(data_out);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved between ticks");

    c_valid: cover property (data_valid);
    c_down: cover property (power_down);
    c_stby: cover property (standby);
endmodule : adc_cfg_checker

bind adc_config_register_bank adc_cfg_checker #(.W(W)) chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rd_data(rd_data),
    .adc_sample(adc_sample), .data_out(data_out), .data_valid(data_valid),
    .sample_tick(sample_tick), .dcs_active(dcs_active), .power_down(power_down),
    .standby(standby)
);

// ---- testbench/host_model.sv ----
// host side of the control port
`timescale 1ns/1ns
`include "adc_cfg_params.svh"
module host_model (
    // clock
    input  wire logic            clk_sys,
    // register port
    output adc_cfg_pkg::reg_req_t req,
    input  wire logic [7:0]      rd_data
);
    initial req = '0;
    // one-cycle write; data flipped once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req.wr_en = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk_sys);
        req.wr_en = 1'b0;
        req.wdata = ~d;
    endtask : wr
    // applies the whole shadow set
    task automatic commit();
        wr(`OFS_TRANSFER, `TRANSFER_CMD);
    endtask : commit
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        req.addr = a;
        @(negedge clk_sys);
        d = rd_data;
    endtask : rd
endmodule : host_model

// ---- testbench/test_adc_config_register_bank.sv ----
// self-checking bench for the config register bank
`timescale 1ns/1ns
`include "adc_cfg_params.svh"
module test_adc_config_register_bank;
    localparam int W = 11;
    localparam logic [7:0] OFS [6] = '{8'h08, 8'h09, 8'h0B, 8'h0D, 8'h10, 8'hFF};
    localparam logic [7:0] RST [6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] TM [3] = '{8'h01, 8'h03, 8'h25};
    localparam logic [10:0] EX [3] = '{11'h000, 11'h400, 11'h7FF};
    logic                  clk_sys    = 1'b0;
    logic                  rst_n      = 1'b0;
    logic [W-1:0]          adc_sample = 11'h123;
    adc_cfg_pkg::reg_req_t req;
    logic [7:0]            rd_data;
    logic [W-1:0]          data_out;
    logic                  data_valid, sample_tick, dcs_active, power_down, standby;
    logic [7:0]            r;
    logic [W-1:0]          w [4];
    int                    n_fail = 0;
    int                    checked = 0;
    int                    k;
    int                    cyc = 0;

    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;

    host_model host (.clk_sys(clk_sys), .req(req), .rd_data(rd_data));
    adc_config_register_bank #(.W(W)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rd_data(rd_data),
        .adc_sample(adc_sample), .data_out(data_out), .data_valid(data_valid),
        .sample_tick(sample_tick), .dcs_active(dcs_active), .power_down(power_down),
        .standby(standby)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // four consecutive valid words
    task automatic grab();
        for (int i = 0; i < 4; i++) begin
            k = 0;
            @(negedge clk_sys);
            while (data_valid !== 1'b1 && k < 40) begin
                @(negedge clk_sys);
                k++;
            end
            w[i] = data_out;
        end
    endtask : grab
    task automatic set(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        host.commit();
        repeat (12) @(negedge clk_sys);
    endtask : set
    task automatic end_sim();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        #(20000 * 50);
        n_fail++;
        $display("unexpected at %0t: timeout", $time);
        end_sim();
    end

    initial begin
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        foreach (OFS[i]) begin
            host.rd(OFS[i], r);
            chk(r, RST[i], "reset value");
        end
        chk(dcs_active, 1, "stabilizer reset");
        // master written, active untouched until commit
        host.wr(`OFS_TEST_PATTERN, 8'h02);
        host.rd(`OFS_TEST_PATTERN, r);
        chk(r, 8'h02, "readback");
        grab();
        chk(w[3], 11'h123, "shadowed");
        host.commit();
        host.rd(`OFS_TRANSFER, r);
        chk(r, 8'h00, "transfer clears");
        grab();
        chk(w[3], 11'h3FF, "positive fs");
        foreach (TM[i]) begin
            set(`OFS_TEST_PATTERN, TM[i]);
            grab();
            chk(w[3], EX[i], "fixed pattern");
        end
        set(`OFS_TEST_PATTERN, 8'h04);
        grab();
        chk(w[0] ^ w[1], 11'h7FF, "checkerboard");
        chk(w[0] == 11'h2AA || w[0] == 11'h555, 1, "checker word");
        set(`OFS_TEST_PATTERN, 8'h07);
        grab();
        chk(w[0] ^ w[1], 11'h7FF, "word toggle");
        chk(w[0] == 11'h000 || w[0] == 11'h7FF, 1, "toggle word");
        for (int m = 5; m < 7; m++) begin
            set(`OFS_TEST_PATTERN, m[7:0]);
            grab();
            chk(w[0] !== w[1] || w[1] !== w[2], 1, "pn moves");
        end
        set(`OFS_TEST_PATTERN, 8'h0F);
        grab();
        chk(11'(w[1] - w[0]), 1, "ramp");
        // user words; only codes the host may use
        host.wr(`OFS_USER1_LO, 8'h34);
        host.wr(`OFS_USER1_HI, 8'h12);
        host.wr(`OFS_USER2_LO, 8'hE0);
        host.wr(`OFS_USER2_HI, 8'hFF);
        host.wr(`OFS_TEST_PATTERN, 8'h88);
        host.commit();
        grab();
        chk({w[0], w[1]}, {11'h091, 11'h7FF}, "single user");
        chk({w[2], w[3]}, 0, "zeros after single");
        set(`OFS_TEST_PATTERN, 8'h08);
        grab();
        chk(w[0] ^ w[1], 11'h091 ^ 11'h7FF, "repeat user");
        chk(w[2], w[0], "repeat again");
        set(`OFS_TEST_PATTERN, 8'h00);
        set(`OFS_OFFSET_TRIM, 8'h3F);
        grab();
        chk(w[3], 11'h122, "converted data");
        for (int d = 0; d < 8; d++) begin
            set(`OFS_CLOCK_DIVIDER, 8'h10 | d[7:0]);
            while (sample_tick !== 1'b1) @(negedge clk_sys);
            @(negedge clk_sys);
            k = 1;
            while (sample_tick !== 1'b1 && k < 20) begin
                @(negedge clk_sys);
                k++;
            end
            chk(k, d + 1, "divide period");
        end
        // phase 2 to phase 5 at ratio 7 moves the tick by three cycles
        while (sample_tick !== 1'b1) @(negedge clk_sys);
        k = cyc;
        set(`OFS_CLOCK_DIVIDER, 8'h2F);
        while (sample_tick !== 1'b1) @(negedge clk_sys);
        chk((cyc - k) % 8, 3, "phase delay");
        set(`OFS_GLOBAL_CLOCK, 8'h00);
        chk(dcs_active, 1, "forced stabilizer");
        set(`OFS_CLOCK_DIVIDER, 8'h00);
        chk(dcs_active, 0, "stabilizer off");
        for (int p = 1; p < 3; p++) begin
            set(`OFS_POWER_MODE, p[7:0]);
            chk({power_down, standby, data_valid}, {p == 1, p == 2, 1'b0}, "power");
            set(`OFS_POWER_MODE, 8'h00);
            grab();
            chk({power_down, standby, w[3]}, {2'b00, 11'h122}, "normal");
        end
        end_sim();
    end
endmodule : test_adc_config_register_bank
